// ### hdl/request_router_pkg.sv
// request router package: register map, field layout, source coding and shared types.
// assumes a 32-bit AXI4-Lite register port and a single system clock.
package request_router_pkg;

  // channel and source counts
  localparam int NUM_CH = 4;
  localparam int NUM_PERIPH = 63;
  localparam int NUM_ALWAYS = 10;
  localparam int NUM_PERIODIC = 2;
  localparam int SRC_W = 7;

  // source coding: 0 selects nothing, then peripheral slots, then always-on slots
  localparam logic [SRC_W-1:0] SRC_PERIPH_FIRST = 7'h01;
  localparam logic [SRC_W-1:0] SRC_ALWAYS_FIRST = 7'h40;
  localparam logic [SRC_W-1:0] SRC_ALWAYS_END = SRC_W'(int'(SRC_ALWAYS_FIRST) + NUM_ALWAYS);

  // register map, byte addresses
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] CFG_BASE = 8'h00;
  localparam logic [ADDR_W-1:0] CTL_BASE = 8'h10;
  localparam logic [ADDR_W-1:0] STAT_OFF = 8'h20;
  localparam int CH_LSB = 2;

  // field positions and byte lanes
  localparam int CFG_EN_BIT = 31;
  localparam int CFG_PER_BIT = 30;
  localparam int CFG_FLAG_LANE = 3;
  localparam int CFG_SRC_LANE = 0;
  localparam int CTL_START_BIT = 0;
  localparam int CTL_START_LANE = 0;

  // bus answers
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic enable;
    logic periodic;
    logic [SRC_W-1:0] source;
  } cfg_t;

  localparam cfg_t CFG_RESET = '{enable: 1'b0, periodic: 1'b0, source: 7'h00};

  // trigger modes, gray along off -> normal -> periodic
  typedef enum logic [1:0] {
    MODE_OFF = 2'h0,
    MODE_NORMAL = 2'h1,
    MODE_PERIODIC = 2'h3
  } mode_t;

  typedef enum logic {
    BUS_IDLE = 1'b0,
    BUS_RESP = 1'b1
  } bus_state_t;

  typedef enum logic [1:0] {
    DEC_NONE = 2'h0,
    DEC_CFG = 2'h1,
    DEC_CTL = 2'h3,
    DEC_STAT = 2'h2
  } dec_kind_t;

  typedef struct packed {
    dec_kind_t kind;
    logic [1:0] ch;
  } dec_t;

  // level of the selected source; unused codes give no request
  function automatic logic src_level(input logic [SRC_W-1:0] src,
                                     input logic [NUM_PERIPH-1:0] periph);
    logic lvl;
    logic [5:0] idx;
    lvl = 1'b0;
    idx = 6'(src - SRC_PERIPH_FIRST);
    if (src >= SRC_PERIPH_FIRST && src < SRC_ALWAYS_FIRST) begin
      lvl = periph[idx];
    end else if (src >= SRC_ALWAYS_FIRST && src < SRC_ALWAYS_END) begin
      lvl = 1'b1;
    end
    return lvl;
  endfunction

endpackage

// ### hdl/route_channel.sv
// route_channel: source select and trigger mode gating for one channel.
// assumes cfg comes from registers; output is combinational, the caller registers it.
`timescale 1ns/10ps
module route_channel #(
  parameter bit PERIODIC_OK = 1'b0
) (
  input request_router_pkg::cfg_t cfg,
  input wire logic [request_router_pkg::NUM_PERIPH-1:0] periph_req,
  input wire logic tick,
  output logic req
);

  request_router_pkg::mode_t mode;
  logic src_lvl;

  // periodic bit is ignored on channels built without the gate
  always_comb begin
    src_lvl = request_router_pkg::src_level(cfg.source, periph_req);
    if (!cfg.enable) begin
      mode = request_router_pkg::MODE_OFF;
    end else if (cfg.periodic && PERIODIC_OK) begin
      mode = request_router_pkg::MODE_PERIODIC;
    end else begin
      mode = request_router_pkg::MODE_NORMAL;
    end
    case (mode)
      request_router_pkg::MODE_OFF: req = 1'b0;
      request_router_pkg::MODE_NORMAL: req = src_lvl;
      request_router_pkg::MODE_PERIODIC: req = src_lvl & tick;
      default: req = 1'b0;
    endcase
  end

endmodule

// ### hdl/request_router.sv
// request_router: routes peripheral and always-on requests to dma channels,
// with per-channel trigger mode and a software start pulse, behind AXI4-Lite.
// assumes one clock clk_sys at 125 MHz and request inputs synchronous to it.
//
// Decided for this implementation: the register offsets and register access over AXI4-Lite.
`timescale 1ns/10ps
// Contract
// - each of 4 channels can take any of 63 peripheral or 10 always-on slots
// - each channel holds a source select field and applies its own trigger mode
// - disabled mode routes no request and keeps the channel off; here a start write still pulses dma_start on a disabled channel
// - after reset all channels are disabled, no request reaches any channel
// - normal mode passes the selected request straight through ungated
// - periodic mode exists on channels 0 and 1 only
// - periodic mode requests only while source and timer tick are both active
// - ten always-asserted sources give timer-only requests in periodic mode
// - writing the start bit in channel control starts that channel's transfer
// - writing zero to a channel configuration disables its routing
module request_router (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic [request_router_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [request_router_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [request_router_pkg::NUM_PERIPH-1:0] periph_req,
  input wire logic [request_router_pkg::NUM_PERIODIC-1:0] tick_trig,
  output logic [request_router_pkg::NUM_CH-1:0] dma_req,
  output logic [request_router_pkg::NUM_CH-1:0] dma_start
);

  localparam int NCH = request_router_pkg::NUM_CH;

  // address decode shared by the read and write paths
  function automatic request_router_pkg::dec_t decode(
      input logic [request_router_pkg::ADDR_W-1:0] a);
    request_router_pkg::dec_t d;
    d.kind = request_router_pkg::DEC_NONE;
    d.ch = a[request_router_pkg::CH_LSB +: 2];
    if (a[1:0] != 2'h0) begin
      d.kind = request_router_pkg::DEC_NONE;
    end else if (a < request_router_pkg::CTL_BASE) begin
      d.kind = request_router_pkg::DEC_CFG;
    end else if (a < request_router_pkg::STAT_OFF) begin
      d.kind = request_router_pkg::DEC_CTL;
    end else if (a == request_router_pkg::STAT_OFF) begin
      d.kind = request_router_pkg::DEC_STAT;
    end
    return d;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // write path and configuration state

  request_router_pkg::bus_state_t wstate_r, wstate_nxt;
  logic aw_held_r, aw_held_nxt, w_held_r, w_held_nxt;
  logic [request_router_pkg::ADDR_W-1:0] aw_addr_r, aw_addr_nxt, wr_addr;
  logic [31:0] w_data_r, w_data_nxt, wr_data;
  logic [3:0] w_strb_r, w_strb_nxt, wr_strb;
  logic [1:0] bresp_r, bresp_nxt;
  logic wr_fire;
  request_router_pkg::dec_t wdec;
  request_router_pkg::cfg_t cfg_r [NCH];
  request_router_pkg::cfg_t cfg_nxt [NCH];
  logic [NCH-1:0] start_r, start_nxt;

  // address and data are caught separately so either may come first
  assign s_axi_awready = (wstate_r == request_router_pkg::BUS_IDLE) && !aw_held_r;
  assign s_axi_wready = (wstate_r == request_router_pkg::BUS_IDLE) && !w_held_r;
  assign wr_addr = aw_held_r ? aw_addr_r : s_axi_awaddr;
  assign wr_data = w_held_r ? w_data_r : s_axi_wdata;
  assign wr_strb = w_held_r ? w_strb_r : s_axi_wstrb;
  assign wr_fire = (wstate_r == request_router_pkg::BUS_IDLE)
                   && (aw_held_r || s_axi_awvalid) && (w_held_r || s_axi_wvalid);
  assign wdec = decode(wr_addr);

  // next state of the write channel, configuration and start pulses
  always_comb begin
    wstate_nxt = wstate_r;
    aw_held_nxt = aw_held_r;
    aw_addr_nxt = aw_addr_r;
    w_held_nxt = w_held_r;
    w_data_nxt = w_data_r;
    w_strb_nxt = w_strb_r;
    bresp_nxt = bresp_r;
    cfg_nxt = cfg_r;
    start_nxt = '0; // start is a pulse, it never reads back
    if (wstate_r == request_router_pkg::BUS_IDLE) begin
      if (wr_fire) begin
        wstate_nxt = request_router_pkg::BUS_RESP;
        aw_held_nxt = 1'b0;
        w_held_nxt = 1'b0;
        bresp_nxt = (wdec.kind == request_router_pkg::DEC_NONE) ?
                    request_router_pkg::RESP_SLVERR : request_router_pkg::RESP_OKAY;
        if (wdec.kind == request_router_pkg::DEC_CFG) begin
          if (wr_strb[request_router_pkg::CFG_FLAG_LANE]) begin
            cfg_nxt[wdec.ch].enable = wr_data[request_router_pkg::CFG_EN_BIT];
            cfg_nxt[wdec.ch].periodic = wr_data[request_router_pkg::CFG_PER_BIT]
                && (int'(wdec.ch) < request_router_pkg::NUM_PERIODIC);
          end
          if (wr_strb[request_router_pkg::CFG_SRC_LANE]) begin
            cfg_nxt[wdec.ch].source = wr_data[request_router_pkg::SRC_W-1:0];
          end
        end
        if (wdec.kind == request_router_pkg::DEC_CTL
            && wr_strb[request_router_pkg::CTL_START_LANE]
            && wr_data[request_router_pkg::CTL_START_BIT]) begin
          start_nxt[wdec.ch] = 1'b1;
        end
      end else begin
        if (s_axi_awvalid && !aw_held_r) begin
          aw_held_nxt = 1'b1;
          aw_addr_nxt = s_axi_awaddr;
        end
        if (s_axi_wvalid && !w_held_r) begin
          w_held_nxt = 1'b1;
          w_data_nxt = s_axi_wdata;
          w_strb_nxt = s_axi_wstrb;
        end
      end
    end else if (s_axi_bready) begin
      wstate_nxt = request_router_pkg::BUS_IDLE;
    end
  end

  // all channels come out of reset disabled
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      wstate_r <= request_router_pkg::BUS_IDLE;
      aw_held_r <= 1'b0;
      aw_addr_r <= '0;
      w_held_r <= 1'b0;
      w_data_r <= '0;
      w_strb_r <= '0;
      bresp_r <= request_router_pkg::RESP_OKAY;
      cfg_r <= '{default: request_router_pkg::CFG_RESET};
      start_r <= '0;
    end else begin
      wstate_r <= wstate_nxt;
      aw_held_r <= aw_held_nxt;
      aw_addr_r <= aw_addr_nxt;
      w_held_r <= w_held_nxt;
      w_data_r <= w_data_nxt;
      w_strb_r <= w_strb_nxt;
      bresp_r <= bresp_nxt;
      cfg_r <= cfg_nxt;
      start_r <= start_nxt;
    end
  end

  assign s_axi_bvalid = (wstate_r == request_router_pkg::BUS_RESP);
  assign s_axi_bresp = bresp_r;

  ////////////////////////////////////////////////////////////////////////////////
  // request routing, one slice per channel

  logic [NCH-1:0] req_r, req_nxt;

  generate
    for (genvar i = 0; i < NCH; i++) begin : g_ch
      if (i < request_router_pkg::NUM_PERIODIC) begin : g_per
        route_channel #(.PERIODIC_OK(1'b1)) u_route (
          .cfg(cfg_r[i]),
          .periph_req(periph_req),
          .tick(tick_trig[i]),
          .req(req_nxt[i])
        );
      end else begin : g_plain
        route_channel #(.PERIODIC_OK(1'b0)) u_route (
          .cfg(cfg_r[i]),
          .periph_req(periph_req),
          .tick(1'b0),
          .req(req_nxt[i])
        );
      end
    end
  endgenerate

  // one register stage keeps the request outputs glitch free
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      req_r <= '0;
    end else begin
      req_r <= req_nxt;
    end
  end

  assign dma_req = req_r;
  assign dma_start = start_r;

  ////////////////////////////////////////////////////////////////////////////////
  // read path

  request_router_pkg::bus_state_t rstate_r, rstate_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [1:0] rresp_r, rresp_nxt;
  request_router_pkg::dec_t rdec;

  assign s_axi_arready = (rstate_r == request_router_pkg::BUS_IDLE);
  assign rdec = decode(s_axi_araddr);

  // data is sampled at the address handshake and held until rready
  always_comb begin
    rstate_nxt = rstate_r;
    rdata_nxt = rdata_r;
    rresp_nxt = rresp_r;
    if (rstate_r == request_router_pkg::BUS_IDLE) begin
      if (s_axi_arvalid) begin
        rstate_nxt = request_router_pkg::BUS_RESP;
        rdata_nxt = '0;
        rresp_nxt = request_router_pkg::RESP_OKAY;
        case (rdec.kind)
          request_router_pkg::DEC_CFG: begin
            rdata_nxt[request_router_pkg::CFG_EN_BIT] = cfg_r[rdec.ch].enable;
            rdata_nxt[request_router_pkg::CFG_PER_BIT] = cfg_r[rdec.ch].periodic;
            rdata_nxt[request_router_pkg::SRC_W-1:0] = cfg_r[rdec.ch].source;
          end
          request_router_pkg::DEC_CTL: rdata_nxt = '0;
          request_router_pkg::DEC_STAT: rdata_nxt[NCH-1:0] = req_r;
          default: rresp_nxt = request_router_pkg::RESP_SLVERR;
        endcase
      end
    end else if (s_axi_rready) begin
      rstate_nxt = request_router_pkg::BUS_IDLE;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rstate_r <= request_router_pkg::BUS_IDLE;
      rdata_r <= '0;
      rresp_r <= request_router_pkg::RESP_OKAY;
    end else begin
      rstate_r <= rstate_nxt;
      rdata_r <= rdata_nxt;
      rresp_r <= rresp_nxt;
    end
  end

  assign s_axi_rvalid = (rstate_r == request_router_pkg::BUS_RESP);
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;

  ////////////////////////////////////////////////////////////////////////////////
  // checks

  logic post_rst_r;

  // marks the first cycle after reset release
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      post_rst_r <= 1'b0;
    end else begin
      post_rst_r <= 1'b1;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  property p_reset_quiet;
    !post_rst_r |-> (dma_req == '0) && (dma_start == '0) && !cfg_r[0].enable;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet)
    else $error("request or start right after reset");

  generate
    for (genvar i = 0; i < NCH; i++) begin : g_chk
      property p_needs_enable;
        dma_req[i] |-> $past(cfg_r[i].enable);
      endproperty
      a_needs_enable: assert property (p_needs_enable)
        else $error("request on a channel that was not enabled");

      property p_off_quiet;
        !cfg_r[i].enable |=> !dma_req[i];
      endproperty
      a_off_quiet: assert property (p_off_quiet)
        else $error("disabled channel raised a request");

      property p_normal_pass;
        cfg_r[i].enable && !cfg_r[i].periodic |=>
          dma_req[i] == $past(request_router_pkg::src_level(cfg_r[i].source, periph_req));
      endproperty
      a_normal_pass: assert property (p_normal_pass)
        else $error("normal mode did not follow the selected source");

      property p_always_on;
        cfg_r[i].enable && !cfg_r[i].periodic
          && cfg_r[i].source >= request_router_pkg::SRC_ALWAYS_FIRST
          && cfg_r[i].source < request_router_pkg::SRC_ALWAYS_END |-> ##1 dma_req[i];
      endproperty
      a_always_on: assert property (p_always_on)
        else $error("always-on slot gave no request");

      property p_start_pulse;
        wr_fire && wdec.kind == request_router_pkg::DEC_CTL && int'(wdec.ch) == i
          && wr_strb[request_router_pkg::CTL_START_LANE]
          && wr_data[request_router_pkg::CTL_START_BIT] |=> dma_start[i] ##1 !dma_start[i];
      endproperty
      a_start_pulse: assert property (p_start_pulse)
        else $error("start write did not give a one-cycle start pulse");

      property p_zero_write;
        wr_fire && wdec.kind == request_router_pkg::DEC_CFG && int'(wdec.ch) == i
          && wr_strb == 4'hf && wr_data == 32'h0 |-> ##2 !dma_req[i] && !cfg_r[i].enable;
      endproperty
      a_zero_write: assert property (p_zero_write)
        else $error("zero configuration write left the channel routing");

      if (i < request_router_pkg::NUM_PERIODIC) begin : g_pchk
        property p_gated;
          dma_req[i] && $past(cfg_r[i].periodic) |-> $past(tick_trig[i])
            && $past(request_router_pkg::src_level(cfg_r[i].source, periph_req));
        endproperty
        a_gated: assert property (p_gated)
          else $error("periodic request without both source and tick");

        property p_tick_only;
          cfg_r[i].enable && cfg_r[i].periodic
            && cfg_r[i].source >= request_router_pkg::SRC_ALWAYS_FIRST
            && cfg_r[i].source < request_router_pkg::SRC_ALWAYS_END
            |=> dma_req[i] == $past(tick_trig[i]);
        endproperty
        a_tick_only: assert property (p_tick_only)
          else $error("always-on slot in periodic mode did not follow tick");
      end else begin : g_nchk
        property p_no_periodic;
          !cfg_r[i].periodic;
        endproperty
        a_no_periodic: assert property (p_no_periodic)
          else $error("periodic mode set on a channel without the gate");
      end
    end
  endgenerate

endmodule

// ### sim/dma_channel_model.sv
// dma channel side model: counts software start pulses per channel.
// assumes dma_start pulses are single-cycle and synchronous to clk_sys.
`timescale 1ns/10ps
module dma_channel_model (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic [request_router_pkg::NUM_CH-1:0] dma_start,
  output logic [31:0] start_cnt
);
  logic [31:0] start_cnt_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // one count per pulse; a start held high would be seen as several transfers
  always_comb begin
    start_cnt_nxt = start_cnt;
    for (int c = 0; c < request_router_pkg::NUM_CH; c++) begin
      if (dma_start[c]) begin
        start_cnt_nxt[c*8 +: 8] = start_cnt[c*8 +: 8] + 8'h01;
      end
    end
  end

  // counters clear with the system reset
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      start_cnt <= 32'h0;
    end else begin
      start_cnt <= start_cnt_nxt;
    end
  end
endmodule

// ### sim/test_request_router.sv
// testbench for request_router: axi4-lite master, random request stimulus, queued checks.
// assumes the design holds each answer until it is taken; the master waits with no fixed count.
`timescale 1ns/10ps
module test_request_router;
  typedef struct {logic rd; logic [31:0] data; logic [1:0] resp;} note_t;
  localparam logic [1:0] OK = request_router_pkg::RESP_OKAY;
  localparam logic [1:0] ERR = request_router_pkg::RESP_SLVERR;
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h0;
  logic [62:0] periph_req = '1;
  logic [1:0] tick_trig = 2'h3;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata, start_cnt, rnd = 32'h362bda56;
  logic [3:0] dma_req, dma_start, exp_st, en, per;
  logic [6:0] code [4];
  logic [6:0] codes [8] = '{7'h01, 7'h3f, 7'h40, 7'h49, 7'h00, 7'h4a, 7'h7f, 7'h20};
  note_t notes [$];
  int fails = 0, n_checks = 0, cycles = 0;

  request_router uut (.clk_sys(clk_sys), .nrst(nrst), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .periph_req(periph_req), .tick_trig(tick_trig),
    .dma_req(dma_req), .dma_start(dma_start));
  dma_channel_model far (.clk_sys(clk_sys), .nrst(nrst), .dma_start(dma_start),
    .start_cnt(start_cnt));

  always #4 clk_sys = ~clk_sys;

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // level a source code should give, worked out independently of the design
  function automatic logic ref_lvl(input logic [6:0] c, input logic [62:0] p);
    if (c >= request_router_pkg::SRC_PERIPH_FIRST && c < request_router_pkg::SRC_ALWAYS_FIRST) begin
      return p[c - 7'h01];
    end
    return c >= request_router_pkg::SRC_ALWAYS_FIRST && c < request_router_pkg::SRC_ALWAYS_END;
  endfunction

  function automatic logic [7:0] cfg_a(input int c);
    return request_router_pkg::CFG_BASE + 8'(4 * c);
  endfunction

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // master write: address and data offered together, each released when taken
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                           input logic [1:0] er);
    logic aw_done, w_done;
    notes.push_back('{1'b0, 32'h0, er});
    aw_done = 1'b0;
    w_done = 1'b0;
    @(posedge clk_sys);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    // the raises above are not visible yet, so each channel is tracked locally
    while (!aw_done || !w_done) begin
      @(posedge clk_sys);
      if (!aw_done && awready) begin
        aw_done = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w_done && wready) begin
        w_done = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge clk_sys); while (bvalid !== 1'b1);
    bready <= 1'b0;
  endtask

  task automatic axi_read(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    notes.push_back('{1'b1, ed, er});
    @(posedge clk_sys);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk_sys); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge clk_sys); while (rvalid !== 1'b1);
    rready <= 1'b0;
  endtask

  // watcher: every answer taken off the bus is matched to the oldest note
  always @(posedge clk_sys) begin
    if (nrst && ((bvalid && bready) || (rvalid && rready))) begin
      if (notes.size() == 0) begin
        check("unexpected answer", 32'h1, 32'h0);
      end else if (notes[0].rd) begin
        check("rdata", rdata, notes[0].data);
        check("rresp", {30'h0, rresp}, {30'h0, notes[0].resp});
        void'(notes.pop_front());
      end else begin
        check("bresp", {30'h0, bresp}, {30'h0, notes[0].resp});
        void'(notes.pop_front());
      end
    end
  end

  // hang guard: the whole sequence needs well under this many cycles
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 40000) begin
      fails++;
      test_done();
    end
  end

  task automatic do_reset();
    nrst <= 1'b0;
    repeat (20) @(posedge clk_sys);
    nrst <= 1'b1;
    @(posedge clk_sys);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    do_reset();
    // all sources and ticks active, yet nothing routed out of reset
    for (int c = 0; c < 4; c++) axi_read(cfg_a(c), 32'h0, OK);
    axi_read(request_router_pkg::STAT_OFF, 32'h0, OK);
    // random modes and sources; boundary codes first
    for (int i = 0; i < 24; i++) begin
      for (int c = 0; c < 4; c++) begin
        rnd = lfsr(rnd);
        code[c] = (i < 8 && c == i % 4) ? codes[i] : 7'(rnd % 32'd76);
        en[c] = rnd[8] | rnd[9] | (i < 8);
        per[c] = rnd[10];
        if (i == 8 && c < 2) begin
          en[c] = 1'b1;
          per[c] = 1'b1;
          code[c] = 7'h45;
        end
        axi_write(cfg_a(c), 32'h0, 4'hf, OK);
        axi_write(cfg_a(c), {en[c], per[c], 23'h0, code[c]}, 4'hf, OK);
        axi_read(cfg_a(c), {en[c], per[c] & (c < 2), 23'h0, code[c]}, OK);
      end
      rnd = lfsr(rnd);
      periph_req <= {rnd[30:0], lfsr(rnd)};
      tick_trig <= rnd[5:4];
      repeat (3) @(posedge clk_sys);
      for (int c = 0; c < 4; c++) begin
        exp_st[c] = en[c] & ref_lvl(code[c], periph_req);
        if (per[c] && c < 2) exp_st[c] = exp_st[c] & tick_trig[c];
      end
      axi_read(request_router_pkg::STAT_OFF, {28'h0, exp_st}, OK);
      check("dma_req", {28'h0, dma_req}, {28'h0, exp_st});
    end
    // zero writes stop all routing even with every source active
    periph_req <= '1;
    tick_trig <= 2'h3;
    for (int c = 0; c < 4; c++) axi_write(cfg_a(c), 32'h0, 4'hf, OK);
    axi_read(request_router_pkg::STAT_OFF, 32'h0, OK);
    // byte lanes: source lane alone, then the mode lane
    axi_write(cfg_a(0), 32'hc000_0005, 4'h1, OK);
    axi_read(cfg_a(0), 32'h0000_0005, OK);
    axi_write(cfg_a(0), 32'hc000_0000, 4'h8, OK);
    axi_read(cfg_a(0), 32'hc000_0005, OK);
    axi_read(request_router_pkg::STAT_OFF, 32'h1, OK);
    tick_trig <= 2'h2;
    repeat (3) @(posedge clk_sys);
    axi_read(request_router_pkg::STAT_OFF, 32'h0, OK);
    // refused and ignored accesses leave the map untouched
    axi_write(8'h24, 32'hffff_ffff, 4'hf, ERR);
    axi_read(8'h24, 32'h0, ERR);
    axi_write(8'h01, 32'h0, 4'hf, ERR);
    axi_write(request_router_pkg::STAT_OFF, 32'hf, 4'hf, OK);
    axi_read(cfg_a(0), 32'hc000_0005, OK);
    // software starts, one per channel, plus a write missing the start lane
    for (int c = 0; c < 4; c++) begin
      axi_write(request_router_pkg::CTL_BASE + 8'(4 * c), 32'h1, 4'hf, OK);
    end
    axi_write(request_router_pkg::CTL_BASE, 32'h1, 4'he, OK);
    axi_read(request_router_pkg::CTL_BASE, 32'h0, OK);
    repeat (2) @(posedge clk_sys);
    check("start_cnt", start_cnt, 32'h0101_0101);
    // second reset in mid-run with an always-on source routed
    axi_write(cfg_a(3), 32'h8000_0040, 4'hf, OK);
    axi_read(request_router_pkg::STAT_OFF, 32'h8, OK);
    do_reset();
    axi_read(cfg_a(3), 32'h0, OK);
    axi_read(request_router_pkg::STAT_OFF, 32'h0, OK);
    repeat (4) @(posedge clk_sys);
    check("notes left", 32'(notes.size()), 32'h0);
    test_done();
  end
endmodule
